// File: inc/rbf_pkg.sv
package rbf_pkg;
   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_STATUS = 8'h0b; // State and cipher flag
   localparam logic [7:0] IDX_BITCTL = 8'h0c; // Receive bit framing
   localparam logic [7:0] IDX_COLL = 8'h0d; // First collision
   localparam logic [7:0] IDX_IRQ_STAT = 8'h20; // Sticky events
   localparam logic [7:0] IDX_IRQ_MASK = 8'h21; // Event enables
   localparam int IDX_LSB = 2; // Lowest address bit of the index
   localparam int IDX_MSB = 9; // Highest address bit of the index
   localparam logic [2:0] HSIZE_WORD = 3'h2; // Only whole words

   // ------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------
   localparam int CIPHER_BIT = 5; // Cipher active flag
   localparam int STATE_W = 3; // Transceiver state field
   localparam int KEEP_BIT = 7; // Keep bits after collision
   localparam int ALIGN_LSB = 4; // First bit position field
   localparam int ALIGN_W = 3;
   localparam int COLLISION_AS_INTEGRITY_ERROR_BIT = 3; // Collision as integrity error
   localparam int LAST_W = 3; // Valid bits of last byte
   localparam int CPV_BIT = 7; // Collision position valid
   localparam int CPOS_W = 7; // Collision position
   localparam logic [6:0] CPOS_MAX = 7'h3f; // Last bit of byte eight
   localparam logic [6:0] CPOS_TOP = 7'h7f; // Counter wraps here and sets the overflow flag

   // ------------------------------------------------------------
   // Interrupt events and reset values
   // ------------------------------------------------------------
   localparam int IRQ_W = 3;
   localparam int IRQ_RXDONE = 0; // Frame received
   localparam int IRQ_COLL = 1; // Collision seen
   localparam int IRQ_INTEG = 2; // Integrity error raised
   localparam logic [7:0] BITCTL_RST = 8'h00;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;

   // Transceiver state, codes as reported to software
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_TRANSMIT_WAIT_STATE = 3'h1,
      ST_TX = 3'h3,
      ST_RECEIVE_WAIT_STATE = 3'h5,
      ST_WAITDATA = 3'h6,
      ST_RX = 3'h7
   } rbf_state_e;
endpackage

// File: inc/rbf_rx_if.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Bit stream from the control logic to the packer
// ------------------------------------------------------------
interface rbf_rx_if;
   logic start; // Reception starts, one cycle
   logic bit_valid; // One data bit this cycle
   logic bit_val; // Its value
   logic coll; // Collision on this bit
   logic eof; // Frame ended
   logic [2:0] align; // First bit position
   logic keep; // Keep bits after collision
   logic byte_valid; // Byte ready, one cycle
   logic [7:0] byte_data; // Packed byte
   logic lb_we; // Last bit count update, one cycle
   logic [2:0] lb_val; // Last bit count
   logic [6:0] coll_pos; // First collision index
   logic coll_pos_valid; // Index is meaningful
   modport ctrl (output start, bit_valid, bit_val, coll, eof, align, keep,
                 input byte_valid, byte_data, lb_we, lb_val, coll_pos, coll_pos_valid);
   modport packer (input start, bit_valid, bit_val, coll, eof, align, keep,
                   output byte_valid, byte_data, lb_we, lb_val, coll_pos, coll_pos_valid);
endinterface
`default_nettype wire

// File: rtl/rbf_bit_packer.sv
`timescale 1ns/1ps
`default_nettype none
module rbf_bit_packer (
   input wire logic clk,
   input wire logic rst,
   rbf_rx_if.packer rx
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [2:0] pos_q, pos_d; // Next bit position in byte
   logic [7:0] data_q, data_d; // Byte under assembly
   logic got_q, got_d; // Current byte holds a bit
   logic [6:0] idx_q, idx_d; // Data bit index incl. offset
   logic ovf_q, ovf_d; // Index ran past its range
   logic cseen_q, cseen_d; // A collision was seen
   logic [6:0] cpos_q, cpos_d; // First collision index
   logic cpv_q, cpv_d; // Index valid
   logic [2:0] align_q, align_d; // Offset of this frame
   logic [7:0] byte_q, byte_d; // Byte out
   logic bv_q, bv_d; // Byte strobe
   logic lbw_q, lbw_d; // Last bit count strobe
   logic [2:0] lb_q, lb_d; // Last bit count
   logic bit_v; // Bit as stored

   // Next state of the packer
   always_comb
   begin
      pos_d = pos_q;
      data_d = data_q;
      got_d = got_q;
      idx_d = idx_q;
      ovf_d = ovf_q;
      cseen_d = cseen_q;
      cpos_d = cpos_q;
      cpv_d = cpv_q;
      align_d = align_q;
      byte_d = byte_q;
      bv_d = 1'b0;
      lbw_d = 1'b0;
      lb_d = lb_q;
      // Bits after the first collision become zero unless kept
      bit_v = rx.bit_val & ~(cseen_q & ~rx.keep); // see R3
      if (rx.start)
      begin
         // Fresh frame: offset applies to position and index
         pos_d = rx.align; // see R4
         idx_d = {4'h0, rx.align}; // see R13
         align_d = rx.align;
         ovf_d = 1'b0;
         cseen_d = 1'b0; // see R16
         cpos_d = '0; // see R16
         cpv_d = 1'b0; // see R16
         data_d = '0;
         got_d = 1'b0;
      end
      else if (rx.bit_valid)
      begin
         data_d[pos_q] = bit_v; // see R4
         if (rx.coll && !cseen_q)
         begin
            // Only the first collision is recorded
            cseen_d = 1'b1; // see R15
            cpos_d = idx_q; // see R11 see R12
            cpv_d = ~ovf_q & (idx_q <= rbf_pkg::CPOS_MAX); // see R10
         end
         idx_d = idx_q + 7'h1;
         if (idx_q == rbf_pkg::CPOS_TOP)
         begin
            ovf_d = 1'b1;
         end
         pos_d = pos_q + 3'h1;
         if (pos_q == 3'h7)
         begin
            // Byte full; offset 7 moves bit two to the next byte
            bv_d = 1'b1; // see R5
            byte_d = data_d;
            data_d = '0;
            got_d = 1'b0;
         end
         else
         begin
            got_d = 1'b1;
         end
      end
      else if (rx.eof)
      begin
         if (got_q)
         begin
            // Flush a partial last byte
            bv_d = 1'b1;
            byte_d = data_q;
            data_d = '0;
            got_d = 1'b0;
         end
         if (align_q != 3'h0)
         begin
            // Bit-oriented frame reports its last byte fill
            lbw_d = 1'b1; // see R6 see R9
            lb_d = pos_q; // see R8
         end
      end
   end

   // Register the packer state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pos_q <= '0;
         data_q <= '0;
         got_q <= 1'b0;
         idx_q <= '0;
         ovf_q <= 1'b0;
         cseen_q <= 1'b0;
         cpos_q <= '0;
         cpv_q <= 1'b0;
         align_q <= '0;
         byte_q <= '0;
         bv_q <= 1'b0;
         lbw_q <= 1'b0;
         lb_q <= '0;
      end
      else
      begin
         pos_q <= pos_d;
         data_q <= data_d;
         got_q <= got_d;
         idx_q <= idx_d;
         ovf_q <= ovf_d;
         cseen_q <= cseen_d;
         cpos_q <= cpos_d;
         cpv_q <= cpv_d;
         align_q <= align_d;
         byte_q <= byte_d;
         bv_q <= bv_d;
         lbw_q <= lbw_d;
         lb_q <= lb_d;
      end
   end

   assign rx.byte_valid = bv_q;
   assign rx.byte_data = byte_q;
   assign rx.lb_we = lbw_q;
   assign rx.lb_val = lb_q;
   assign rx.coll_pos = cpos_q;
   assign rx.coll_pos_valid = cpv_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb_p @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_first_coll;
      // First bit of a frame: nothing stored yet, still at the offset
      rx.bit_valid && rx.coll && !got_q && (pos_q == align_q) && (idx_q < 7'h8);
   endsequence
   property p_offset_in_pos;
      s_first_coll |=> rx.coll_pos_valid && (rx.coll_pos == {4'h0, $past(align_q)});
   endproperty
   a_offset_in_pos: assert property (p_offset_in_pos) else $error("collision index lacks offset"); // see R13

   sequence s_coll_at_zero;
      rx.bit_valid && rx.coll && !rx.keep && (pos_q == 3'h0);
   endsequence
   sequence s_seven_bits;
      (rx.bit_valid && !rx.keep && !rx.start) [*7];
   endsequence
   property p_zero_after;
      s_coll_at_zero ##1 s_seven_bits |=> rx.byte_valid && (rx.byte_data[7:1] == '0);
   endproperty
   a_zero_after: assert property (p_zero_after) else $error("bits after collision not zeroed"); // see R3
endmodule // rbf_bit_packer
`default_nettype wire

// File: rtl/rbf_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: Cipher flag: auth sets, host write clears
// R2: Report transceiver state as 3-bit code
// R3: Cleared keep bit zeroes bits after collision
// R4: First bit stored at start position field
// R5: Offset seven spills second bit into next byte
// R6: Zero offset byte-oriented, else bit-oriented
// R7: Optionally flag collisions as integrity errors
// R8: Report valid bits of last byte
// R9: Decoder writes count at end, clears at start
// R10: Position valid flag only when meaningful
// R11: First collision index over first eight bytes
// R12: Index is zero-based bit number
// R13: Start offset is added into the index
// R14: Host trusts index only when flagged valid
// R15: Collision sets flag and stores position
// R16: Clear position and flag at reception start
module rbf_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic txrx_go,
   input wire logic tx_start,
   input wire logic tx_done,
   input wire logic rx_ready,
   input wire logic rx_sof,
   input wire logic rx_bit_valid,
   input wire logic rx_bit,
   input wire logic rx_bit_coll,
   input wire logic rx_eof,
   input wire logic rx_check_err,
   input wire logic cancel,
   input wire logic cipher_auth_ok,
   output logic [2:0] txrx_state,
   output logic cipher_active,
   output logic rx_byte_valid,
   output logic [7:0] rx_byte,
   output logic collision_detected,
   output logic integrity_error,
   output logic irq
);
   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   logic ap_ok; // Valid word transfer in address phase
   logic wr_pend_q, wr_pend_d; // Write data phase pending
   logic [7:0] wr_idx_q, wr_idx_d; // Its register index
   logic [31:0] rdata_q, rdata_d; // Read data, from a flop
   logic [7:0] ap_idx; // Index being addressed
   logic wr_stat, wr_bitctl, wr_istat, wr_imask; // Write strobes

   // Control and status registers
   logic cipher_q, cipher_d; // Cipher active
   logic keep_q, keep_d; // Keep bits after collision
   logic [2:0] align_q, align_d; // First bit position
   logic collision_as_integrity_error_q, collision_as_integrity_error_d; // Collision as integrity error
   logic [2:0] lb_q, lb_d; // Valid bits of last byte
   logic cdet_q, cdet_d; // Collision detected
   logic integ_q, integ_d; // Integrity error
   logic [2:0] istat_q, istat_d; // Sticky events
   logic [2:0] imask_q, imask_d; // Event enables
   logic [2:0] events; // Events of this cycle

   // Transceiver sequencing
   rbf_pkg::rbf_state_e state_q, state_d;
   logic rx_start; // Reception begins this cycle
   logic bit_in; // A data bit is taken
   logic coll_in; // That bit collided
   logic eof_in; // Frame end is taken

   rbf_rx_if rx_if ();

   // Address phase decode; only whole words are served, address bits 1:0 are ignored
   assign ap_ok = hsel && hready && htrans[1] && (hsize == rbf_pkg::HSIZE_WORD);
   assign ap_idx = haddr[rbf_pkg::IDX_MSB:rbf_pkg::IDX_LSB];
   assign wr_stat = wr_pend_q && (wr_idx_q == rbf_pkg::IDX_STATUS);
   assign wr_bitctl = wr_pend_q && (wr_idx_q == rbf_pkg::IDX_BITCTL);
   assign wr_istat = wr_pend_q && (wr_idx_q == rbf_pkg::IDX_IRQ_STAT);
   assign wr_imask = wr_pend_q && (wr_idx_q == rbf_pkg::IDX_IRQ_MASK);

   // Next bus state and read data; unmapped reads return zero
   always_comb
   begin
      wr_pend_d = 1'b0;
      wr_idx_d = wr_idx_q;
      rdata_d = '0;
      if (ap_ok && (haddr[31:rbf_pkg::IDX_MSB + 1] == '0))
      begin
         wr_pend_d = hwrite;
         wr_idx_d = ap_idx;
         if (!hwrite)
         begin
            // Reads sample the register before a write in flight lands
            unique case (ap_idx)
               rbf_pkg::IDX_STATUS:
               begin
                  rdata_d[rbf_pkg::CIPHER_BIT] = cipher_q; // see R1
                  rdata_d[rbf_pkg::STATE_W - 1:0] = state_q; // see R2
               end
               rbf_pkg::IDX_BITCTL:
               begin
                  rdata_d[rbf_pkg::KEEP_BIT] = keep_q;
                  rdata_d[rbf_pkg::ALIGN_LSB +: rbf_pkg::ALIGN_W] = align_q;
                  rdata_d[rbf_pkg::COLLISION_AS_INTEGRITY_ERROR_BIT] = collision_as_integrity_error_q;
                  rdata_d[rbf_pkg::LAST_W - 1:0] = lb_q; // see R8
               end
               rbf_pkg::IDX_COLL:
               begin
                  rdata_d[rbf_pkg::CPV_BIT] = rx_if.coll_pos_valid; // see R10
                  rdata_d[rbf_pkg::CPOS_W - 1:0] = rx_if.coll_pos; // see R11
               end
               rbf_pkg::IDX_IRQ_STAT:
               begin
                  rdata_d[rbf_pkg::IRQ_W - 1:0] = istat_q;
               end
               rbf_pkg::IDX_IRQ_MASK:
               begin
                  rdata_d[rbf_pkg::IRQ_W - 1:0] = imask_q;
               end
               default:
               begin
                  rdata_d = '0;
               end
            endcase
         end
      end
   end

   // Register the bus state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= '0;
         rdata_q <= '0;
      end
      else
      begin
         wr_pend_q <= wr_pend_d;
         wr_idx_q <= wr_idx_d;
         rdata_q <= rdata_d;
      end
   end

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;

   // ------------------------------------------------------------
   // Transceiver state machine
   // ------------------------------------------------------------
   assign rx_start = (state_q == rbf_pkg::ST_RECEIVE_WAIT_STATE) && rx_ready && !cancel;
   assign bit_in = (state_q == rbf_pkg::ST_RX) && rx_bit_valid && !cancel;
   assign coll_in = bit_in && rx_bit_coll;
   assign eof_in = (state_q == rbf_pkg::ST_RX) && rx_eof && !rx_bit_valid && !cancel;

   // Next state; cancel returns to idle from anywhere
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         rbf_pkg::ST_IDLE:
         begin
            if (txrx_go)
            begin
               state_d = rbf_pkg::ST_TRANSMIT_WAIT_STATE;
            end
         end
         rbf_pkg::ST_TRANSMIT_WAIT_STATE:
         begin
            if (tx_start)
            begin
               state_d = rbf_pkg::ST_TX;
            end
         end
         rbf_pkg::ST_TX:
         begin
            if (tx_done)
            begin
               state_d = rbf_pkg::ST_RECEIVE_WAIT_STATE;
            end
         end
         rbf_pkg::ST_RECEIVE_WAIT_STATE:
         begin
            if (rx_ready)
            begin
               state_d = rbf_pkg::ST_WAITDATA;
            end
         end
         rbf_pkg::ST_WAITDATA:
         begin
            if (rx_sof)
            begin
               state_d = rbf_pkg::ST_RX;
            end
         end
         rbf_pkg::ST_RX:
         begin
            if (eof_in)
            begin
               state_d = rbf_pkg::ST_IDLE;
            end
         end
         default:
         begin
            // The unused codes 2 and 4 recover to idle
            state_d = rbf_pkg::ST_IDLE; // see R2
         end
      endcase
      if (cancel)
      begin
         state_d = rbf_pkg::ST_IDLE;
      end
   end

   // Register the state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_q <= rbf_pkg::ST_IDLE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------
   // Control, error and event registers
   // ------------------------------------------------------------
   assign events[rbf_pkg::IRQ_RXDONE] = eof_in;
   assign events[rbf_pkg::IRQ_COLL] = coll_in;
   assign events[rbf_pkg::IRQ_INTEG] = (coll_in && collision_as_integrity_error_q) || (bit_in && rx_check_err);

   // Next register values; hardware sets win over software clears
   always_comb
   begin
      cipher_d = cipher_q;
      keep_d = keep_q;
      align_d = align_q;
      collision_as_integrity_error_d = collision_as_integrity_error_q;
      lb_d = lb_q;
      cdet_d = cdet_q;
      integ_d = integ_q;
      imask_d = imask_q;
      istat_d = istat_q | events;
      if (wr_stat && !hwdata[rbf_pkg::CIPHER_BIT])
      begin
         // Software may only switch the cipher off
         cipher_d = 1'b0; // see R1
      end
      if (cipher_auth_ok)
      begin
         cipher_d = 1'b1; // see R1
      end
      if (wr_bitctl)
      begin
         keep_d = hwdata[rbf_pkg::KEEP_BIT];
         align_d = hwdata[rbf_pkg::ALIGN_LSB +: rbf_pkg::ALIGN_W]; // see R4
         collision_as_integrity_error_d = hwdata[rbf_pkg::COLLISION_AS_INTEGRITY_ERROR_BIT];
         lb_d = hwdata[rbf_pkg::LAST_W - 1:0];
      end
      if (rx_start)
      begin
         // Stale results of the last frame are dropped
         lb_d = '0; // see R9
         cdet_d = 1'b0;
         integ_d = 1'b0;
      end
      if (rx_if.lb_we)
      begin
         lb_d = rx_if.lb_val; // see R9
      end
      if (coll_in)
      begin
         cdet_d = 1'b1; // see R15
      end
      if (events[rbf_pkg::IRQ_INTEG])
      begin
         integ_d = 1'b1; // see R7
      end
      if (wr_istat)
      begin
         istat_d = (istat_q & ~hwdata[rbf_pkg::IRQ_W - 1:0]) | events;
      end
      if (wr_imask)
      begin
         imask_d = hwdata[rbf_pkg::IRQ_W - 1:0];
      end
   end

   // Register control and status
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cipher_q <= 1'b0;
         keep_q <= rbf_pkg::BITCTL_RST[rbf_pkg::KEEP_BIT];
         align_q <= rbf_pkg::BITCTL_RST[rbf_pkg::ALIGN_LSB +: rbf_pkg::ALIGN_W];
         collision_as_integrity_error_q <= rbf_pkg::BITCTL_RST[rbf_pkg::COLLISION_AS_INTEGRITY_ERROR_BIT];
         lb_q <= rbf_pkg::BITCTL_RST[rbf_pkg::LAST_W - 1:0];
         cdet_q <= 1'b0;
         integ_q <= 1'b0;
         istat_q <= '0;
         imask_q <= rbf_pkg::IRQ_MASK_RST;
      end
      else
      begin
         cipher_q <= cipher_d;
         keep_q <= keep_d;
         align_q <= align_d;
         collision_as_integrity_error_q <= collision_as_integrity_error_d;
         lb_q <= lb_d;
         cdet_q <= cdet_d;
         integ_q <= integ_d;
         istat_q <= istat_d;
         imask_q <= imask_d;
      end
   end

   // ------------------------------------------------------------
   // Bit packer
   // ------------------------------------------------------------
   assign rx_if.start = rx_start; // see R16
   assign rx_if.bit_valid = bit_in;
   assign rx_if.bit_val = rx_bit;
   assign rx_if.coll = coll_in;
   assign rx_if.eof = eof_in;
   assign rx_if.align = align_q; // see R6
   assign rx_if.keep = keep_q; // see R3

   rbf_bit_packer u_packer (
      .clk (clk),
      .rst (rst),
      .rx (rx_if.packer)
   );

   assign txrx_state = state_q;
   assign cipher_active = cipher_q;
   assign rx_byte_valid = rx_if.byte_valid;
   assign rx_byte = rx_if.byte_data;
   assign collision_detected = cdet_q;
   assign integrity_error = integ_q;
   assign irq = |(istat_q & imask_q);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb_t @(posedge clk); endclocking
   default disable iff (rst);

   property p_cipher_auth;
      $rose(cipher_active) |-> $past(cipher_auth_ok);
   endproperty
   a_cipher_auth: assert property (p_cipher_auth) else $error("cipher set without auth"); // see R1

   property p_cipher_clear;
      (wr_stat && !hwdata[rbf_pkg::CIPHER_BIT] && !cipher_auth_ok) |=> !cipher_active;
   endproperty
   a_cipher_clear: assert property (p_cipher_clear) else $error("cipher not cleared"); // see R1

   property p_state_path;
      (txrx_state == 3'h0 && txrx_go && !cancel) |=> (txrx_state == 3'h1) ##0 (txrx_state != 3'h4);
   endproperty
   a_state_path: assert property (p_state_path) else $error("bad state code"); // see R2

   property p_integ_coll;
      (coll_in && collision_as_integrity_error_q) |=> integrity_error && collision_detected;
   endproperty
   a_integ_coll: assert property (p_integ_coll) else $error("collision not integrity error"); // see R7

   property p_rx_clear;
      rx_start |=> !collision_detected && (lb_q == '0) && !rx_if.coll_pos_valid;
   endproperty
   a_rx_clear: assert property (p_rx_clear) else $error("stale result at start"); // see R16

   property p_last_bits;
      (eof_in && align_q != '0) |=> ##1 (lb_q == $past(rx_if.lb_val));
   endproperty
   a_last_bits: assert property (p_last_bits) else $error("last bit count not written"); // see R9

   property p_irq_set_wins;
      (coll_in && wr_istat && hwdata[rbf_pkg::IRQ_COLL]) |=> istat_q[rbf_pkg::IRQ_COLL];
   endproperty
   a_irq_set_wins: assert property (p_irq_set_wins) else $error("event lost on clear"); // see R15
endmodule // rbf_top
`default_nettype wire

// File: dv/rbf_card.sv
`timescale 1ns/1ps
`default_nettype none
// Card model: one frame a request, sof, bits LSB first, then eof
module rbf_card (
   input wire logic clk,
   input wire logic send,
   input wire logic [3:0] nbits,
   input wire logic [15:0] data,
   input wire logic [15:0] cmask,
   output logic rx_sof,
   output logic rx_bit_valid,
   output logic rx_bit,
   output logic rx_bit_coll,
   output logic rx_eof
);
   initial
   begin
      rx_sof = 1'b0;
      rx_bit_valid = 1'b0;
      rx_bit = 1'b0;
      rx_bit_coll = 1'b0;
      rx_eof = 1'b0;
   end
   // The bit line is inverted once released, so stale data never looks valid
   always @(posedge clk)
   begin
      if (send)
      begin
         rx_sof <= 1'b1;
         @(posedge clk) rx_sof <= 1'b0;
         for (int i = 0; i < nbits; i++)
         begin
            rx_bit_valid <= 1'b1;
            rx_bit <= data[i];
            rx_bit_coll <= cmask[i];
            @(posedge clk);
         end
         rx_bit_valid <= 1'b0;
         rx_bit <= ~rx_bit;
         rx_bit_coll <= 1'b0;
         rx_eof <= 1'b1;
         @(posedge clk) rx_eof <= 1'b0;
      end
   end
endmodule // rbf_card
`default_nettype wire

// File: dv/test_rx_bit_framing_collision_status.sv
`timescale 1ns/1ps
`default_nettype none
module test_rx_bit_framing_collision_status;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic auth = 1'b0;
   logic snd = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [3:0] seq = 4'h0;
   logic [3:0] nb = 4'h0;
   logic [15:0] dat = 16'h0;
   logic [15:0] cm = 16'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic [2:0] st;
   logic [7:0] byt;
   logic hrdy, hresp, cact, bv, cdet, ierr, irq, sof, bval, bit_v, bcol, eof;
   logic [7:0] q[$];
   int n_mismatch = 0;
   int num_checks = 0;
   rbf_top rbf_top_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata),
      .txrx_go(seq[0]), .tx_start(seq[1]), .tx_done(seq[2]), .rx_ready(seq[3]), .rx_sof(sof),
      .rx_bit_valid(bval), .rx_bit(bit_v), .rx_bit_coll(bcol), .rx_eof(eof), .rx_check_err(1'b0),
      .cancel(1'b0), .cipher_auth_ok(auth), .txrx_state(st), .cipher_active(cact), .rx_byte_valid(bv),
      .rx_byte(byt), .collision_detected(cdet), .integrity_error(ierr), .irq(irq));
   rbf_card rbf_card_i (.clk(clk), .send(snd), .nbits(nb), .data(dat), .cmask(cm), .rx_sof(sof),
      .rx_bit_valid(bval), .rx_bit(bit_v), .rx_bit_coll(bcol), .rx_eof(eof));
   always #10 clk = ~clk;
   // Collect every byte the packer hands on
   always @(posedge clk) if (bv === 1'b1) q.push_back(byt);
   // -------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(logic [7:0] idx, logic wr, logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {22'h0, idx, 2'h0};
      do @(posedge clk); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask
   task automatic reg_is(string nm, logic [7:0] idx, logic [31:0] exp);
      bus(idx, 1'b0, 32'h0);
      chk(nm, rd, exp);
   endtask
   // Full exchange: program framing, walk the states, let the card answer
   task automatic frame(logic [7:0] ctl, logic [3:0] n, logic [15:0] d, logic [15:0] c);
      logic [2:0] code[4] = '{3'h1, 3'h3, 3'h5, 3'h6};
      bus(rbf_pkg::IDX_BITCTL, 1'b1, {24'h0, ctl});
      q.delete();
      for (int k = 0; k < 4; k++)
      begin
         @(posedge clk) seq <= 4'h1 << k;
         @(posedge clk) seq <= 4'h0;
         #1 chk("state", st, code[k]);
      end
      nb <= n;
      dat <= d;
      cm <= c;
      @(posedge clk) snd <= 1'b1;
      @(posedge clk) snd <= 1'b0;
      @(posedge clk) #1 chk("state", st, 3'h7);
      for (int i = 0; i < 40 && st !== 3'h0; i++) @(posedge clk);
      repeat (3) @(posedge clk);
   endtask
   // -------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------
   task automatic t_reset;
      reg_is("status", rbf_pkg::IDX_STATUS, 32'h0);
      reg_is("bitctl", rbf_pkg::IDX_BITCTL, 32'h0);
      reg_is("coll", rbf_pkg::IDX_COLL, 32'h0);
      reg_is("unmapped", 8'hff, 32'h0);
   endtask
   // Offset seven, collision on first bit, later bits zeroed, flagged as integrity
   task automatic t_bits;
      frame(8'h78, 4'h3, 16'h7, 16'h1);
      chk("byte0", q[0], 8'h80);
      chk("byte1", q[1], 8'h00);
      reg_is("lastbits", rbf_pkg::IDX_BITCTL, 32'h7a);
      reg_is("coll", rbf_pkg::IDX_COLL, 32'h87);
      chk("integ", {cdet, ierr}, 2'h3);
      reg_is("istat", rbf_pkg::IDX_IRQ_STAT, 32'h7);
      chk("irq", irq, 1'b0);
      bus(rbf_pkg::IDX_IRQ_MASK, 1'b1, 32'h2);
      #1 chk("irq", irq, 1'b1);
      bus(rbf_pkg::IDX_IRQ_STAT, 1'b1, 32'h2);
      reg_is("istat", rbf_pkg::IDX_IRQ_STAT, 32'h5);
      chk("irq", irq, 1'b0);
   endtask
   // Byte oriented: keep bits with collision on third bit, then no collision, then cleared keep with collision on first bit
   task automatic t_keep;
      frame(8'h80, 4'h8, 16'hff, 16'h4);
      chk("byte", q[0], 8'hff);
      reg_is("coll", rbf_pkg::IDX_COLL, 32'h82);
      chk("integ", {cdet, ierr}, 2'h2);
      frame(8'h00, 4'h8, 16'ha5, 16'h0);
      chk("byte", q[0], 8'ha5);
      reg_is("coll", rbf_pkg::IDX_COLL, 32'h0);
      reg_is("bitctl", rbf_pkg::IDX_BITCTL, 32'h0);
      frame(8'h00, 4'h8, 16'ha5, 16'h1);
      chk("byte", q[0], 8'h01);
   endtask
   task automatic t_cipher;
      @(posedge clk) auth <= 1'b1;
      @(posedge clk) auth <= 1'b0;
      reg_is("cipher", rbf_pkg::IDX_STATUS, 32'h20);
      chk("cact", {hresp, cact}, 2'h1);
      bus(rbf_pkg::IDX_STATUS, 1'b1, 32'hff);
      reg_is("cipher", rbf_pkg::IDX_STATUS, 32'h20);
      bus(rbf_pkg::IDX_STATUS, 1'b1, 32'h0);
      reg_is("cipher", rbf_pkg::IDX_STATUS, 32'h0);
   endtask
   task automatic test_done;
      if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_bits();
      t_keep();
      t_cipher();
      test_done();
   end
   // Watchdog well past the under two hundred cycles the run needs
   initial
   begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      test_done();
   end
endmodule // test_rx_bit_framing_collision_status
`default_nettype wire
